// ### pkg/ccr_defines.vh
// ----------------------------------------
// constants for the calibration control registers
// ----------------------------------------
// assumes a single 25 MHz device clock and a byte-wide register port
`ifndef CCR_DEFINES_VH
`define CCR_DEFINES_VH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define CCR_ADDR_TRIM       8'h59
`define CCR_ADDR_PLL_RESET  8'h5C
`define CCR_ADDR_TUNE_CTRL  8'h5D
`define CCR_ADDR_TUNE_STAT  8'h5E
`define CCR_ADDR_CAL_RUN    8'h61
`define CCR_ADDR_CAL_CFG    8'h62

// ----------------------------------------
// field positions
// ----------------------------------------
`define CCR_TRIM_MSB        6
`define CCR_SETTLE_MSB      6
`define CCR_SETTLE_LSB      4
`define CCR_TUNE_EN_BIT     0
`define CCR_TUNE_DONE_BIT   0
`define CCR_PLL_RESET_BIT   0
`define CCR_CAL_RUN_BIT     0
`define CCR_BG_OFFSET_BIT   3
`define CCR_FG_OFFSET_BIT   2
`define CCR_BG_ON_BIT       1
`define CCR_FG_RUN_BIT      0

// ----------------------------------------
// reset values
// ----------------------------------------
`define CCR_RST_TRIM        7'h00
`define CCR_RST_PLL_RESET   1'h0
`define CCR_RST_SETTLE      3'h4
`define CCR_RST_TUNE_EN     1'h0
`define CCR_RST_CAL_RUN     1'h1
`define CCR_RST_CAL_CFG     4'h1

// ----------------------------------------
// timing
// ----------------------------------------
`define CCR_CLK_MHZ         25
`define CCR_SETTLE_BASE_NS  640
`define CCR_SETTLE_BASE_CYC ((`CCR_SETTLE_BASE_NS * `CCR_CLK_MHZ + 999) / 1000)

`endif

// ### tb/ccr_regs_assertions.sv
// ----------------------------------------
// checker for the calibration control registers
// ----------------------------------------
// assumes binding to ccr_regs and sight of its ports only
`timescale 1ns/1ps
`default_nettype none
`include "ccr_defines.vh"
module ccr_chk #(
  parameter TRIM_W = 7
) (
  // clock and reset
  input wire logic              CLK,
  input wire logic              RSTN,
  // register port
  input wire logic [7:0]        REG_ADDR,
  input wire logic [7:0]        REG_WDATA,
  input wire logic              REG_WE,
  input wire logic              REG_RE,
  input wire logic [7:0]        REG_RDATA,
  // engines
  input wire logic              OSC_TOO_FAST,
  input wire logic [TRIM_W-1:0] OSC_TRIM,
  input wire logic              PLL_RESET,
  input wire logic              FG_COMPLETE,
  input wire logic              CAL_CORE_RSTN,
  input wire logic              DIV_RSTN,
  input wire logic              CAL_VALUES_CLEAR,
  input wire logic              FG_TUNING_ACTIVE,
  input wire logic              BG_TUNING_ON,
  input wire logic              FG_OFFSET_ON,
  input wire logic              BG_OFFSET_ON,
  input wire logic              FG_DONE
);
  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RSTN);
  a_div_follow_run:
    assert property ((REG_WE && REG_ADDR == `CCR_ADDR_CAL_RUN) |=> ##1
      (DIV_RSTN == $past(REG_WDATA[0], 2))) else $error("divider reset off run bit");
  a_core_follow_run:
    assert property ((REG_WE && REG_ADDR == `CCR_ADDR_CAL_RUN) |=> ##1
      (CAL_CORE_RSTN == $past(REG_WDATA[0], 2))) else $error("core reset off run bit");
  a_clear_on_start:
    assert property ($rose(CAL_CORE_RSTN) |-> CAL_VALUES_CLEAR ##1 !CAL_VALUES_CLEAR)
      else $error("clear pulse wrong at start");
  a_hold_quiet:
    assert property (!CAL_CORE_RSTN |-> !(FG_TUNING_ACTIVE || FG_DONE || BG_TUNING_ON
      || FG_OFFSET_ON || BG_OFFSET_ON || CAL_VALUES_CLEAR)) else $error("active in hold");
  a_fg_offset_gate:
    assert property (FG_OFFSET_ON |-> FG_TUNING_ACTIVE) else $error("fg offset ungated");
  a_bg_offset_gate:
    assert property (BG_OFFSET_ON |-> BG_TUNING_ON && FG_DONE) else $error("bg offset ungated");
  a_trim_settles:
    assert property ((!PLL_RESET && $changed(OSC_TRIM)) |=> $stable(OSC_TRIM)[*8])
      else $error("trim moved before settling");
  a_status_resv:
    assert property ((REG_RE && REG_ADDR == `CCR_ADDR_TUNE_STAT) |=> REG_RDATA[7:1] == 7'h00)
      else $error("status reserved bits set");
  c_fg_done: cover property ($rose(FG_DONE));
  c_bg_offset: cover property (BG_OFFSET_ON);
  c_div_hold: cover property ($fell(DIV_RSTN));
endmodule // ccr_chk
bind ccr_regs ccr_chk #(.TRIM_W(TRIM_W)) u_chk (
  .CLK(CLK), .RSTN(RSTN), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
  .REG_WE(REG_WE), .REG_RE(REG_RE), .REG_RDATA(REG_RDATA),
  .OSC_TOO_FAST(OSC_TOO_FAST), .OSC_TRIM(OSC_TRIM), .PLL_RESET(PLL_RESET),
  .FG_COMPLETE(FG_COMPLETE), .CAL_CORE_RSTN(CAL_CORE_RSTN), .DIV_RSTN(DIV_RSTN),
  .CAL_VALUES_CLEAR(CAL_VALUES_CLEAR), .FG_TUNING_ACTIVE(FG_TUNING_ACTIVE),
  .BG_TUNING_ON(BG_TUNING_ON), .FG_OFFSET_ON(FG_OFFSET_ON),
  .BG_OFFSET_ON(BG_OFFSET_ON), .FG_DONE(FG_DONE)
);
`default_nettype wire

// ### tb/ccr_regs_tb.sv
// ----------------------------------------
// self-checking bench for the calibration control registers
// ----------------------------------------
// assumes ccr_regs and its bound checker compiled alongside
`timescale 1ns/1ps
`default_nettype none
`include "ccr_defines.vh"
module tb;
  logic       CLK, RSTN, REG_WE, REG_RE, FG_COMPLETE;
  logic [7:0] REG_ADDR, REG_WDATA;
  wire  [7:0] REG_RDATA;
  wire  [6:0] OSC_TRIM;
  wire        OSC_TOO_FAST, PLL_RESET, CAL_CORE_RSTN, DIV_RSTN, CAL_VALUES_CLEAR;
  wire        FG_TUNING_ACTIVE, BG_TUNING_ON, FG_OFFSET_ON, BG_OFFSET_ON, FG_DONE;
  int         n_errors, num_checks;
  // oscillator runs fast above trim 0x2B
  assign OSC_TOO_FAST = (OSC_TRIM > 7'h2B);
  ccr_regs #(.TRIM_W(7)) uut (
    .CLK(CLK), .RSTN(RSTN), .REG_ADDR(REG_ADDR), .REG_WDATA(REG_WDATA),
    .REG_WE(REG_WE), .REG_RE(REG_RE), .REG_RDATA(REG_RDATA),
    .OSC_TOO_FAST(OSC_TOO_FAST), .OSC_TRIM(OSC_TRIM), .PLL_RESET(PLL_RESET),
    .FG_COMPLETE(FG_COMPLETE), .CAL_CORE_RSTN(CAL_CORE_RSTN), .DIV_RSTN(DIV_RSTN),
    .CAL_VALUES_CLEAR(CAL_VALUES_CLEAR), .FG_TUNING_ACTIVE(FG_TUNING_ACTIVE),
    .BG_TUNING_ON(BG_TUNING_ON), .FG_OFFSET_ON(FG_OFFSET_ON),
    .BG_OFFSET_ON(BG_OFFSET_ON), .FG_DONE(FG_DONE)
  );
  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic give_verdict;
    $display("checks %0d errors %0d", num_checks, n_errors);
    if (n_errors == 0 && num_checks > 0)
      $display("SIMULATION PASSED");
    else
      $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    num_checks++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic lim(input int k, input int m);
    if (k >= m) begin
      n_errors++;
      $display("unexpected t=%0t wait ran out %h %h", $time, k, m);
      give_verdict;
    end
  endtask
  task automatic cyc;
    @(posedge CLK);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    REG_ADDR = a;
    REG_WDATA = d;
    REG_WE = 1'b1;
    cyc;
    REG_WE = 1'b0;
    cyc;
  endtask
  task automatic rdq(input logic [7:0] a);
    REG_ADDR = a;
    REG_RE = 1'b1;
    cyc;
    REG_RE = 1'b0;
    cyc;
  endtask
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    rdq(a);
    chk(REG_RDATA, e);
  endtask
  task automatic cal(input logic [7:0] cfg);
    int k;
    k = 0;
    wr(`CCR_ADDR_CAL_RUN, 8'h00);
    chk(8'({DIV_RSTN, CAL_CORE_RSTN, FG_DONE, BG_TUNING_ON}), 8'h00);
    wr(`CCR_ADDR_CAL_CFG, cfg);
    rd(`CCR_ADDR_CAL_CFG, cfg);
    wr(`CCR_ADDR_CAL_RUN, 8'h01);
    chk(8'(CAL_VALUES_CLEAR), 8'h01);
    while (FG_DONE !== 1'b1 && FG_TUNING_ACTIVE !== 1'b1 && k < 20) begin
      cyc;
      k++;
    end
    lim(k, 20);
    repeat (2) cyc;
  endtask
  task automatic fin;
    FG_COMPLETE = 1'b1;
    cyc;
    FG_COMPLETE = 1'b0;
    repeat (3) cyc;
    chk(8'({FG_DONE, FG_TUNING_ACTIVE, FG_OFFSET_ON}), 8'h04);
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_reset_map;
    rd(`CCR_ADDR_TRIM, 8'h00);
    rd(`CCR_ADDR_PLL_RESET, 8'h00);
    rd(`CCR_ADDR_TUNE_CTRL, 8'h40);
    rd(`CCR_ADDR_TUNE_STAT, 8'h01);
    rd(`CCR_ADDR_CAL_RUN, 8'h01);
    rd(`CCR_ADDR_CAL_CFG, 8'h01);
    wr(`CCR_ADDR_TUNE_STAT, 8'h00);
    rd(`CCR_ADDR_TUNE_STAT, 8'h01);
    rd(8'h70, 8'h00);
  endtask
  task automatic t_cal;
    chk(8'({FG_TUNING_ACTIVE, FG_DONE}), 8'h02);
    fin;
    cal(8'h0E);
    chk(8'({FG_DONE, BG_TUNING_ON, BG_OFFSET_ON, FG_OFFSET_ON}), 8'h0E);
    cal(8'h0C);
    chk(8'({FG_DONE, BG_TUNING_ON, BG_OFFSET_ON, FG_OFFSET_ON}), 8'h08);
    cal(8'h05);
    chk(8'({FG_TUNING_ACTIVE, FG_OFFSET_ON, BG_OFFSET_ON}), 8'h06);
    fin;
  endtask
  task automatic t_tune(input int s);
    int c;
    logic [6:0] t;
    c = 0;
    t = OSC_TRIM;
    wr(`CCR_ADDR_PLL_RESET, 8'h01);
    chk(8'(PLL_RESET), 8'h01);
    wr(`CCR_ADDR_TUNE_CTRL, 8'(s << 4) | 8'h01);
    rd(`CCR_ADDR_TUNE_STAT, 8'h00);
    repeat (40) cyc;
    chk(8'(OSC_TRIM), 8'(t));
    wr(`CCR_ADDR_PLL_RESET, 8'h00);
    chk(8'(PLL_RESET), 8'h00);
    do begin
      rdq(`CCR_ADDR_TUNE_STAT);
      c += 2;
    end while (REG_RDATA[0] !== 1'b1 && c < 1000);
    lim(c, 1000);
    chk(8'(c >= 7 * (16 << s) && c <= 7 * ((16 << s) + 3) + 12), 8'h01);
    rd(`CCR_ADDR_TRIM, 8'h2B);
    chk(8'(OSC_TRIM), 8'h2B);
  endtask
  task automatic t_trim;
    wr(`CCR_ADDR_TRIM, 8'h11);
    rd(`CCR_ADDR_TRIM, 8'h11);
    chk(8'(OSC_TRIM), 8'h11);
  endtask
  // ----------------------------------------
  // clock and main sequence
  // ----------------------------------------
  initial begin
    CLK = 1'b0;
    forever #20 CLK = ~CLK;
  end
  initial begin
    RSTN = 1'b0;
    REG_WE = 1'b0;
    REG_RE = 1'b0;
    REG_ADDR = 8'h00;
    REG_WDATA = 8'h00;
    FG_COMPLETE = 1'b0;
    n_errors = 0;
    num_checks = 0;
    repeat (3) @(posedge CLK);
    #1;
    RSTN = 1'b1;
    repeat (4) cyc;
    t_reset_map;
    t_cal;
    t_tune(0);
    t_tune(2);
    t_trim;
    give_verdict;
  end
endmodule // tb
`default_nettype wire

// ### verilog/ccr_regs.v
// ----------------------------------------
// calibration control registers and converter calibration sequencer
// ----------------------------------------
// assumes a synchronous byte-wide register port and analog engines
// that report on plain level inputs
`timescale 1ns/1ps
`default_nettype none
`include "ccr_defines.vh"

// Behaviour
// - settle select, bits 6:4, reset 4, lengthens wait after each trim change
// - tuning starts only when enabled and PLL reset bit goes back to zero
// - engine adjusts trim code by itself to centre oscillator frequency
// - done flag reads one after tuning, or at once when tuning skipped
// - run bit, reset one: high runs calibration, low holds it in reset
// - clearing run bit also resets processing and serial clock dividers
// - bit 3 enables background offset calibration, only with background on
// - bit 2 enables foreground offset calibration, only with foreground run
// - bit 1 enables background calibration, reset value zero
// - bit 0 clears values always, then runs foreground when one
// - trim code bits 6:0 written by engine, readable for later reuse
module ccr_regs #(
  parameter TRIM_W = 7
) (
  // clock and reset
  input  wire              CLK,
  input  wire              RSTN,
  // register port
  input  wire [7:0]        REG_ADDR,
  input  wire [7:0]        REG_WDATA,
  input  wire              REG_WE,
  input  wire              REG_RE,
  output reg  [7:0]        REG_RDATA,
  // oscillator tuning
  input  wire              OSC_TOO_FAST,
  output reg  [TRIM_W-1:0] OSC_TRIM,
  output reg               PLL_RESET,
  // converter calibration
  input  wire              FG_COMPLETE,
  output reg               CAL_CORE_RSTN,
  output reg               DIV_RSTN,
  output reg               CAL_VALUES_CLEAR,
  output reg               FG_TUNING_ACTIVE,
  output reg               BG_TUNING_ON,
  output reg               FG_OFFSET_ON,
  output reg               BG_OFFSET_ON,
  output reg               FG_DONE
);

  // ----------------------------------------
  // sequencer states
  // ----------------------------------------
  localparam [3:0] CS_HOLD  = 4'h1;
  localparam [3:0] CS_CLEAR = 4'h2;
  localparam [3:0] CS_FG    = 4'h4;
  localparam [3:0] CS_READY = 4'h8;

  reg              pll_reset_reg;
  reg [2:0]        settle_reg;
  reg              tune_en_reg;
  reg              cal_run_reg;
  reg [3:0]        cal_cfg_reg;
  reg [TRIM_W-1:0] trim_reg;
  reg [3:0]        cstate_reg;
  reg [3:0]        cstate_next;
  reg [7:0]        rdata_next;

  wire             eng_wr;
  wire [TRIM_W-1:0] eng_val;
  wire             eng_done;
  wire             eng_busy;
  wire             wr_trim;

  // ----------------------------------------
  // tuning engine
  // ----------------------------------------
  // held by PLL reset
  ccr_tune_engine #(
    .TRIM_W     (TRIM_W)
  ) u_tune (
    .clk        (CLK),
    .rst_n      (RSTN),
    .hold       (pll_reset_reg),
    .enable     (tune_en_reg),
    .settle_sel (settle_reg),
    .too_fast   (OSC_TOO_FAST),
    .trim_wr    (eng_wr),
    .trim_val   (eng_val),
    .done       (eng_done)
  );

  // tuning in flight: enabled, released, not yet done
  assign eng_busy = tune_en_reg & ~pll_reset_reg & ~eng_done;
  assign wr_trim  = REG_WE && (REG_ADDR == `CCR_ADDR_TRIM);

  // ----------------------------------------
  // register writes
  // ----------------------------------------
  always @(posedge CLK) begin
    if (!RSTN) begin
      pll_reset_reg <= `CCR_RST_PLL_RESET;
      settle_reg    <= `CCR_RST_SETTLE;
      tune_en_reg   <= `CCR_RST_TUNE_EN;
      cal_run_reg   <= `CCR_RST_CAL_RUN;
      cal_cfg_reg   <= `CCR_RST_CAL_CFG;
      trim_reg      <= `CCR_RST_TRIM;
    end else begin
      if (REG_WE) begin
        case (REG_ADDR)
          `CCR_ADDR_PLL_RESET: begin
            pll_reset_reg <= REG_WDATA[`CCR_PLL_RESET_BIT];
          end
          `CCR_ADDR_TUNE_CTRL: begin
            settle_reg  <= REG_WDATA[`CCR_SETTLE_MSB:`CCR_SETTLE_LSB];
            tune_en_reg <= REG_WDATA[`CCR_TUNE_EN_BIT];
          end
          `CCR_ADDR_CAL_RUN: begin
            cal_run_reg <= REG_WDATA[`CCR_CAL_RUN_BIT];
          end
          `CCR_ADDR_CAL_CFG: begin
            cal_cfg_reg <= REG_WDATA[3:0];
          end
          default: begin
            cal_run_reg <= cal_run_reg;
          end
        endcase
      end
      if (eng_wr) begin
        trim_reg <= eng_val;
      end else if (wr_trim && !eng_busy) begin
        trim_reg <= REG_WDATA[`CCR_TRIM_MSB:0];
      end
    end
  end

  // ----------------------------------------
  // register reads, one cycle latency
  // ----------------------------------------
  always @* begin
    rdata_next = 8'h00;
    case (REG_ADDR)
      `CCR_ADDR_TRIM:      rdata_next = {1'b0, trim_reg};
      `CCR_ADDR_PLL_RESET: rdata_next = {7'h00, pll_reset_reg};
      `CCR_ADDR_TUNE_CTRL: rdata_next = {1'b0, settle_reg, 3'h0, tune_en_reg};
      `CCR_ADDR_TUNE_STAT: rdata_next = {7'h00, eng_done};
      `CCR_ADDR_CAL_RUN:   rdata_next = {7'h00, cal_run_reg};
      `CCR_ADDR_CAL_CFG:   rdata_next = {4'h0, cal_cfg_reg};
      default:             rdata_next = 8'h00;
    endcase
  end

  always @(posedge CLK) begin
    if (!RSTN) begin
      REG_RDATA <= 8'h00;
    end else if (REG_RE) begin
      REG_RDATA <= rdata_next;
    end
  end

  // ----------------------------------------
  // converter calibration sequencer
  // ----------------------------------------
  always @* begin
    cstate_next = cstate_reg;
    case (cstate_reg)
      CS_HOLD: begin
        if (cal_run_reg) begin
          cstate_next = CS_CLEAR;
        end
      end
      CS_CLEAR: begin
        if (cal_cfg_reg[`CCR_FG_RUN_BIT]) begin
          cstate_next = CS_FG;
        end else begin
          cstate_next = CS_READY;
        end
      end
      CS_FG: begin
        if (FG_COMPLETE) begin
          cstate_next = CS_READY;
        end
      end
      CS_READY: begin
        cstate_next = CS_READY;
      end
      default: begin
        cstate_next = CS_HOLD;
      end
    endcase
    if (!cal_run_reg) begin
      cstate_next = CS_HOLD;
    end
  end

  always @(posedge CLK) begin
    if (!RSTN) begin
      cstate_reg       <= CS_HOLD;
      CAL_CORE_RSTN    <= 1'b0;
      DIV_RSTN         <= 1'b0;
      CAL_VALUES_CLEAR <= 1'b0;
      FG_TUNING_ACTIVE <= 1'b0;
      BG_TUNING_ON     <= 1'b0;
      FG_OFFSET_ON     <= 1'b0;
      BG_OFFSET_ON     <= 1'b0;
      FG_DONE          <= 1'b0;
      OSC_TRIM         <= `CCR_RST_TRIM;
      PLL_RESET        <= 1'b1;
    end else begin
      cstate_reg       <= cstate_next;
      CAL_CORE_RSTN    <= cal_run_reg;
      DIV_RSTN         <= cal_run_reg;
      CAL_VALUES_CLEAR <= (cstate_next == CS_CLEAR);
      FG_TUNING_ACTIVE <= (cstate_next == CS_FG);
      FG_DONE          <= (cstate_next == CS_READY);
      BG_TUNING_ON     <= (cstate_next == CS_READY) & cal_cfg_reg[`CCR_BG_ON_BIT];
      FG_OFFSET_ON     <= (cstate_next == CS_FG) & cal_cfg_reg[`CCR_FG_OFFSET_BIT]
                          & cal_cfg_reg[`CCR_FG_RUN_BIT];
      BG_OFFSET_ON     <= (cstate_next == CS_READY) & cal_cfg_reg[`CCR_BG_OFFSET_BIT]
                          & cal_cfg_reg[`CCR_BG_ON_BIT];
      OSC_TRIM         <= trim_reg;
      PLL_RESET        <= pll_reset_reg;
    end
  end

endmodule // ccr_regs

`default_nettype wire

// ### verilog/ccr_tune_engine.v
// ----------------------------------------
// oscillator tuning engine: binary search of the trim code
// ----------------------------------------
// assumes a comparator flag that is high while the oscillator runs fast
`timescale 1ns/1ps
`default_nettype none
`include "ccr_defines.vh"

module ccr_tune_engine #(
  parameter TRIM_W = 7
) (
  // clock and reset
  input  wire              clk,
  input  wire              rst_n,
  // control
  input  wire              hold,
  input  wire              enable,
  input  wire [2:0]        settle_sel,
  input  wire              too_fast,
  // results
  output reg               trim_wr,
  output reg  [TRIM_W-1:0] trim_val,
  output reg               done
);

  localparam [3:0] ST_IDLE = 4'h1;
  localparam [3:0] ST_WAIT = 4'h2;
  localparam [3:0] ST_FIN  = 4'h4;
  localparam [3:0] ST_HOLD = 4'h8;
  localparam integer SETTLE_BASE_I = `CCR_SETTLE_BASE_CYC;
  localparam [11:0]  SETTLE_BASE   = SETTLE_BASE_I[11:0];

  reg [3:0]        state_reg;
  reg [11:0]       cnt_reg;
  reg [TRIM_W-1:0] mask_reg;
  wire [11:0]      settle_cyc;
  wire [TRIM_W-1:0] kept;

  assign settle_cyc = (SETTLE_BASE << settle_sel) - 12'h001;
  // drop the trial bit when the oscillator overshoots
  assign kept = too_fast ? (trim_val & ~mask_reg) : trim_val;

  always @(posedge clk) begin
    trim_wr <= 1'b0;
    if (!rst_n || hold) begin
      state_reg <= ST_HOLD;
      cnt_reg   <= 12'h000;
      mask_reg  <= {TRIM_W{1'b0}};
      trim_val  <= {TRIM_W{1'b0}};
      done      <= 1'b0;
    end else begin
      case (state_reg)
        ST_HOLD: begin
          state_reg <= ST_IDLE;
        end
        ST_IDLE: begin
          if (enable) begin
            mask_reg  <= {1'b1, {(TRIM_W-1){1'b0}}};
            trim_val  <= {1'b1, {(TRIM_W-1){1'b0}}};
            trim_wr   <= 1'b1;
            cnt_reg   <= settle_cyc;
            state_reg <= ST_WAIT;
          end else begin
            done      <= 1'b1;
            state_reg <= ST_FIN;
          end
        end
        ST_WAIT: begin
          if (cnt_reg != 12'h000) begin
            cnt_reg <= cnt_reg - 12'h001;
          end else begin
            trim_wr  <= 1'b1;
            mask_reg <= mask_reg >> 1;
            cnt_reg  <= settle_cyc;
            if (mask_reg[0]) begin
              trim_val  <= kept;
              done      <= 1'b1;
              state_reg <= ST_FIN;
            end else begin
              trim_val <= kept | (mask_reg >> 1);
            end
          end
        end
        ST_FIN: begin
          state_reg <= ST_FIN;
        end
        default: begin
          state_reg <= ST_HOLD;
        end
      endcase
    end
  end

endmodule // ccr_tune_engine

`default_nettype wire
